// ---- rtl/cgl_params.svh ----
// Constants of the compressor gain-limit and activity-detect block
// Assumes inclusion by bare name from every file that needs an offset or count
`ifndef CGL_PARAMS_SVH
`define CGL_PARAMS_SVH

// ********************************
// Register indices (byte address is four times)
// ********************************
`define CGL_IDX_CTRL1 10'h114
`define CGL_IDX_CTRL3 10'h116
`define CGL_IDX_LIMIT 10'h117
`define CGL_IDX_THRESH 10'h118
`define CGL_IDX_STATUS 10'h119
`define CGL_IDX_CLEAR 10'h11A
`define CGL_IDX_IRQEN 10'h11B
`define CGL_IDX_LEVEL 10'h11C

// ********************************
// Field positions and reset values
// ********************************
`define CGL_C1_ENA 0
`define CGL_C1_PATH 1
`define CGL_C1_CLIP 2
`define CGL_C1_QR 3
`define CGL_C1_DET 4
`define CGL_C1_DETSEL 5
`define CGL_C1_GATE 6
`define CGL_C3_QRTHR 10
`define CGL_C3_QRDCY 8
`define CGL_C3_ATK 4
`define CGL_C3_DCY 0
`define CGL_CTRL1_RST 16'h0008
`define CGL_CTRL3_RST 16'h0044
`define CGL_LIMIT_RST 32'h0001_4004
`define CGL_THRESH_RST 32'h2002_1001

// ********************************
// Gain, level and timing
// ********************************
`define CGL_UNITY 8'h10
`define CGL_CLIP_LVL 16'h6000
`define CGL_CLIP_HOLD 8'hFF
`define CGL_CLIP_SH 3
`define CGL_LA_DEPTH 4
`define CGL_CLK_NS 10
`define CGL_STEPS_6DB 16
`define CGL_QRD0_NS 725000
`define CGL_QRD1_NS 1450000
`define CGL_QRD2_NS 5800000

`endif

// ---- rtl/cgl_pkg.sv ----
// Types and helpers shared by the compressor modules
// Assumes nothing beyond a SystemVerilog compiler
package cgl_pkg;
	// Signed audio sample
	typedef logic signed [15:0] cgl_smp_t;
	// Gain, unsigned Q4.4, unity is 0x10
	typedef logic [7:0] cgl_gain_t;
	// Operating region, one-hot
	typedef enum logic [2:0] {
		CGL_RG_OFF = 3'b001,
		CGL_RG_COMP = 3'b010,
		CGL_RG_GATE = 3'b100
	} cgl_region_t;

	// Magnitude; full negative maps to 0x8000
	function automatic logic [15:0] cgl_abs(input cgl_smp_t s);
		cgl_abs = s[15] ? 16'(-s) : 16'(s);
	endfunction
endpackage

// ---- rtl/cgl_link_if.sv ----
// Sample and level bundle between the top and its two helpers
// Assumes all parties run on the same clock
`timescale 1ns/1ns
`default_nettype none
interface cgl_link_if;
	cgl_pkg::cgl_smp_t smp; // Selected input sample
	logic vld; // Sample strobe
	logic [15:0] peak; // Peak tracker
	logic [15:0] avg; // Averaged level
	cgl_pkg::cgl_smp_t dly_smp; // Look-ahead delayed sample
	logic dly_vld; // Delayed strobe
	modport top (output smp, output vld, input peak, input avg, input dly_smp, input dly_vld);
	modport meter (input smp, input vld, output peak, output avg);
	modport delay (input smp, input vld, output dly_smp, output dly_vld);
endinterface
`default_nettype wire

// ---- rtl/cgl_level_meter.sv ----
// Peak and averaged-level tracker of the compressor input
// Assumes samples arrive as one-cycle strobes on the link
`timescale 1ns/1ns
`default_nettype none
`include "cgl_params.svh"
module cgl_level_meter (
	input wire logic clock_in,
	input wire logic rst_in,
	cgl_link_if.meter lk
);
	// ********************************
	// Level tracking
	// ********************************
	logic [15:0] mag; // Current magnitude
	logic [15:0] peak_fall; // Peak after release
	logic signed [16:0] diff; // Error to average
	assign mag = cgl_pkg::cgl_abs(lk.smp);
	assign peak_fall = lk.peak - (lk.peak >> 4);
	assign diff = $signed({1'b0, mag}) - $signed({1'b0, lk.avg});

	// Fast attack peak, leaky average with 1/64 weight
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			lk.peak <= 16'h0000;
			lk.avg <= 16'h0000;
		end else if (lk.vld) begin
			lk.peak <= (mag > peak_fall) ? mag : peak_fall;
			lk.avg <= lk.avg + 16'(diff >>> 6);
		end
	end
endmodule
`default_nettype wire

// ---- rtl/cgl_lookahead.sv ----
// Sample delay line feeding the clip guard look-ahead
// Assumes the top chooses between this and the undelayed sample
`timescale 1ns/1ns
`default_nettype none
`include "cgl_params.svh"
module cgl_lookahead (
	input wire logic clock_in,
	input wire logic rst_in,
	cgl_link_if.delay lk
);
	// ********************************
	// Delay stages
	// ********************************
	cgl_pkg::cgl_smp_t stage_q [`CGL_LA_DEPTH]; // Shift stages

	// First stage takes each new sample
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			stage_q[0] <= 16'sh0000;
		end else if (lk.vld) begin
			stage_q[0] <= lk.smp;
		end
	end

	// Remaining stages advance on each sample
	for (genvar i = 1; i < `CGL_LA_DEPTH; i++) begin : g_stage
		always_ff @(posedge clock_in or posedge rst_in) begin
			if (rst_in) begin
				stage_q[i] <= 16'sh0000;
			end else if (lk.vld) begin
				stage_q[i] <= stage_q[i-1];
			end
		end
	end

	// Output lags by the full depth of samples
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			lk.dly_smp <= 16'sh0000;
			lk.dly_vld <= 1'b0;
		end else begin
			lk.dly_vld <= lk.vld;
			if (lk.vld) begin
				lk.dly_smp <= stage_q[`CGL_LA_DEPTH-1];
			end
		end
	end
endmodule
`default_nettype wire

// ---- rtl/cgl_top.sv ----
// Compressor gain limits, release control and activity detect
// Assumes one 100 MHz clock, an Avalon-MM master, and
// sample strobes from same-clock logic in both audio paths
`timescale 1ns/1ns
`default_nettype none
`include "cgl_params.svh"
module cgl_top #(
	parameter int unsigned ATK_BASE_CYC = 64, // Attack step base
	parameter int unsigned DCY_BASE_CYC = 1024, // Decay step base
	parameter int unsigned QR_STEP0 = `CGL_QRD0_NS / (`CGL_CLK_NS * `CGL_STEPS_6DB),
	parameter int unsigned QR_STEP1 = `CGL_QRD1_NS / (`CGL_CLK_NS * `CGL_STEPS_6DB),
	parameter int unsigned QR_STEP2 = `CGL_QRD2_NS / (`CGL_CLK_NS * `CGL_STEPS_6DB)
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [11:0] address_in,
	input wire logic read_in,
	input wire logic write_in,
	input wire logic [31:0] writedata_in,
	output logic [31:0] readdata_out,
	output logic waitrequest_out,
	input wire cgl_pkg::cgl_smp_t rec_sample_in,
	input wire logic rec_valid_in,
	input wire cgl_pkg::cgl_smp_t play_sample_in,
	input wire logic play_valid_in,
	output cgl_pkg::cgl_smp_t proc_sample_out,
	output logic proc_valid_out,
	output logic irq_out,
	output logic activity_out
);
	// ********************************
	// Helpers
	// ********************************
	// Crest factor test: peak above average scaled by 4x..32x
	function automatic logic crest_over(input logic [15:0] pk, input logic [15:0] av, input logic [1:0] code);
		logic [20:0] scaled;
		scaled = {5'h00, av} << (5'(code) + 5'h02);
		crest_over = {5'h00, pk} > scaled;
	endfunction

	// ********************************
	// Register state
	// ********************************
	logic wait_q; // Bus wait, low for one answer cycle
	logic [31:0] rdata_q; // Read data
	logic [15:0] ctrl1_q; // Enables and selects
	logic [15:0] ctrl3_q; // Rate and threshold codes
	logic [31:0] limit_q; // Gain floors and ceiling
	logic [31:0] thresh_q; // Level thresholds
	logic [2:0] status_q; // Sticky events
	logic [2:0] irq_en_q; // Interrupt enables
	logic irq_q; // Interrupt line
	logic activity_q; // Activity pin level
	logic wr_go; // Write takes effect
	logic rd_take; // Read data captured
	logic [9:0] widx; // Word index
	logic [2:0] clr; // Status clear mask
	logic [2:0] ev; // Events this cycle

	assign widx = address_in[11:2];
	assign wr_go = write_in && !wait_q;
	assign rd_take = read_in && wait_q;
	assign clr = (wr_go && widx == `CGL_IDX_CLEAR) ? writedata_in[2:0] : 3'h0;

	// ********************************
	// Field views
	// ********************************
	logic comp_en, path_sel, clip_en, qr_en, det_en, det_sel, gate_en;
	logic [1:0] qr_thr, qr_dcy;
	logic [3:0] atk_code, dcy_code;
	cgl_pkg::cgl_gain_t comp_min, max_gain, gate_min;
	logic [1:0] pk_thr;
	logic [7:0] rms_thr, gate_lvl, knee_lvl;
	assign comp_en = ctrl1_q[`CGL_C1_ENA];
	assign path_sel = ctrl1_q[`CGL_C1_PATH];
	assign clip_en = ctrl1_q[`CGL_C1_CLIP];
	assign qr_en = ctrl1_q[`CGL_C1_QR];
	assign det_en = ctrl1_q[`CGL_C1_DET];
	assign det_sel = ctrl1_q[`CGL_C1_DETSEL];
	assign gate_en = ctrl1_q[`CGL_C1_GATE];
	assign qr_thr = ctrl3_q[`CGL_C3_QRTHR +: 2];
	assign qr_dcy = ctrl3_q[`CGL_C3_QRDCY +: 2];
	assign atk_code = ctrl3_q[`CGL_C3_ATK +: 4];
	assign dcy_code = ctrl3_q[`CGL_C3_DCY +: 4];
	assign comp_min = limit_q[7:0];
	assign max_gain = limit_q[15:8];
	assign gate_min = limit_q[23:16];
	assign pk_thr = thresh_q[1:0];
	assign rms_thr = thresh_q[15:8];
	assign gate_lvl = thresh_q[23:16];
	assign knee_lvl = thresh_q[31:24];

	// ********************************
	// Bus slave
	// ********************************
	// One wait cycle, then a one-cycle low answer
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= !((read_in || write_in) && wait_q);
		end
	end

	// Register writes; unmapped writes are dropped
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl1_q <= `CGL_CTRL1_RST;
			ctrl3_q <= `CGL_CTRL3_RST;
			limit_q <= `CGL_LIMIT_RST;
			thresh_q <= `CGL_THRESH_RST;
			irq_en_q <= 3'h0;
		end else if (wr_go) begin
			case (widx)
				`CGL_IDX_CTRL1: ctrl1_q <= {9'h000, writedata_in[6:0]};
				`CGL_IDX_CTRL3: ctrl3_q <= {4'h0, writedata_in[11:0]};
				`CGL_IDX_LIMIT: limit_q <= {8'h00, writedata_in[23:0]};
				`CGL_IDX_THRESH: thresh_q <= {writedata_in[31:8], 6'h00, writedata_in[1:0]};
				`CGL_IDX_IRQEN: irq_en_q <= writedata_in[2:0];
				default: ;
			endcase
		end
	end

	// ********************************
	// Input path and helpers
	// ********************************
	cgl_link_if lk ();
	cgl_pkg::cgl_region_t region_q; // Operating region
	cgl_pkg::cgl_gain_t gain_q; // Applied gain
	cgl_pkg::cgl_gain_t gain_d; // Next gain

	// Only one path feeds the compressor at a time
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			lk.smp <= 16'sh0000;
			lk.vld <= 1'b0;
		end else begin
			lk.smp <= path_sel ? play_sample_in : rec_sample_in;
			lk.vld <= path_sel ? play_valid_in : rec_valid_in;
		end
	end

	cgl_level_meter u_meter (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.lk(lk.meter)
	);

	cgl_lookahead u_ahead (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.lk(lk.delay)
	);

	// ********************************
	// Level decisions
	// ********************************
	logic loud; // Average above knee
	logic crest_hi; // Transient over fast release threshold
	logic falling; // Gain heads down
	logic act_d; // Activity condition
	assign loud = lk.avg[15:8] > knee_lvl;
	assign crest_hi = crest_over(lk.peak, lk.avg, qr_thr);
	assign falling = loud || (region_q == cgl_pkg::CGL_RG_GATE);
	// Peak mode when select is high, RMS mode otherwise
	assign act_d = comp_en && det_en && (det_sel ? crest_over(lk.peak, lk.avg, pk_thr)
		: (lk.avg[15:8] > rms_thr));

	// Region follows enable and gate level
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			region_q <= cgl_pkg::CGL_RG_OFF;
		end else if (!comp_en) begin
			region_q <= cgl_pkg::CGL_RG_OFF;
		end else if (gate_en && lk.avg[15:8] < gate_lvl) begin
			region_q <= cgl_pkg::CGL_RG_GATE;
		end else begin
			region_q <= cgl_pkg::CGL_RG_COMP;
		end
	end

	// ********************************
	// Clip guard
	// ********************************
	logic [7:0] clip_hold_q; // Boost hold counter
	logic clip_hit; // Raw sample nears full scale
	assign clip_hit = comp_en && clip_en && lk.vld && (cgl_pkg::cgl_abs(lk.smp) > `CGL_CLIP_LVL);

	// Undelayed sample spots the rise before it reaches the gain stage
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			clip_hold_q <= 8'h00;
		end else if (clip_hit) begin
			clip_hold_q <= `CGL_CLIP_HOLD;
		end else if (clip_hold_q != 8'h00) begin
			clip_hold_q <= clip_hold_q - 8'h01;
		end
	end

	// ********************************
	// Step timing
	// ********************************
	logic [25:0] atk_int, dcy_int, qr_int, rate_int; // Cycles per step
	logic [25:0] step_cnt_q; // Cycles since last step
	logic step; // Gain may move now

	// Step interval from the active rate
	always_comb begin
		atk_int = 26'(ATK_BASE_CYC) << atk_code;
		if (clip_hold_q != 8'h00) begin
			atk_int = atk_int >> `CGL_CLIP_SH;
		end
		dcy_int = 26'(DCY_BASE_CYC) << dcy_code;
		unique case (qr_dcy)
			2'h1: qr_int = 26'(QR_STEP1);
			2'h2: qr_int = 26'(QR_STEP2);
			default: qr_int = 26'(QR_STEP0);
		endcase
		if (falling) begin
			rate_int = atk_int;
		end else if (qr_en && crest_hi) begin
			rate_int = qr_int;
		end else begin
			rate_int = dcy_int;
		end
	end
	assign step = (region_q != cgl_pkg::CGL_RG_OFF) && (step_cnt_q >= rate_int);

	// Free-running step counter while active
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			step_cnt_q <= 26'h0;
		end else if (region_q == cgl_pkg::CGL_RG_OFF || step) begin
			step_cnt_q <= 26'h0;
		end else begin
			step_cnt_q <= step_cnt_q + 26'h1;
		end
	end

	// ********************************
	// Gain update
	// ********************************
	// Clamp runs every cycle so new limits bite at once
	always_comb begin
		gain_d = gain_q;
		unique case (region_q)
			cgl_pkg::CGL_RG_OFF: gain_d = `CGL_UNITY;
			cgl_pkg::CGL_RG_COMP, cgl_pkg::CGL_RG_GATE: begin
				if (step && falling && gain_q != 8'h00) begin
					gain_d = gain_q - 8'h01;
				end else if (step && !falling && gain_q != 8'hFF) begin
					gain_d = gain_q + 8'h01;
				end
				if (region_q == cgl_pkg::CGL_RG_GATE && gain_d < gate_min) begin
					gain_d = gate_min;
				end else if (region_q == cgl_pkg::CGL_RG_COMP && gain_d < comp_min) begin
					gain_d = comp_min;
				end
				if (gain_d > max_gain) begin
					gain_d = max_gain;
				end
			end
			default: gain_d = `CGL_UNITY;
		endcase
	end

	// Applied gain register
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			gain_q <= `CGL_UNITY;
		end else begin
			gain_q <= gain_d;
		end
	end

	// ********************************
	// Output datapath
	// ********************************
	cgl_pkg::cgl_smp_t src_smp; // Delayed or direct sample
	logic src_vld; // Its strobe
	logic signed [24:0] prod; // Sample times gain
	logic signed [20:0] scaled; // Back to sample scale
	// Look-ahead delay only when the clip guard is on
	assign src_smp = clip_en ? lk.dly_smp : lk.smp;
	assign src_vld = clip_en ? lk.dly_vld : lk.vld;
	assign prod = src_smp * $signed({1'b0, gain_q});
	assign scaled = prod[24:4];

	// Saturate rather than wrap on overload
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			proc_sample_out <= 16'sh0000;
			proc_valid_out <= 1'b0;
		end else begin
			proc_valid_out <= src_vld;
			if (src_vld) begin
				if (scaled[20:15] == {6{scaled[20]}}) begin
					proc_sample_out <= scaled[15:0];
				end else begin
					proc_sample_out <= scaled[20] ? 16'sh8000 : 16'sh7FFF;
				end
			end
		end
	end

	// ********************************
	// Events and interrupt
	// ********************************
	assign ev = {step && !falling && qr_en && crest_hi, clip_hit, act_d};

	// Set wins over a clear in the same cycle
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			status_q <= 3'h0;
			activity_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			status_q <= (status_q & ~clr) | ev;
			activity_q <= act_d;
			irq_q <= |(status_q & irq_en_q);
		end
	end
	assign activity_out = activity_q;
	assign irq_out = irq_q;

	// Read capture; unmapped and clear read as zero
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_q <= 32'h0;
		end else if (rd_take) begin
			case (widx)
				`CGL_IDX_CTRL1: rdata_q <= {16'h0000, ctrl1_q};
				`CGL_IDX_CTRL3: rdata_q <= {16'h0000, ctrl3_q};
				`CGL_IDX_LIMIT: rdata_q <= limit_q;
				`CGL_IDX_THRESH: rdata_q <= thresh_q;
				`CGL_IDX_STATUS: rdata_q <= {29'h0, status_q};
				`CGL_IDX_IRQEN: rdata_q <= {29'h0, irq_en_q};
				`CGL_IDX_LEVEL: rdata_q <= {8'h00, gain_q, lk.avg};
				default: rdata_q <= 32'h0;
			endcase
		end
	end
	assign readdata_out = rdata_q;
	assign waitrequest_out = wait_q;

	// ********************************
	// Checks
	// ********************************
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (rst_in);

	AST_COMP_FLOOR: assert property (
		region_q == cgl_pkg::CGL_RG_COMP && comp_min <= max_gain |=> gain_q >= $past(comp_min))
		else $error("gain below compression floor");
	AST_GATE_FLOOR: assert property (
		region_q == cgl_pkg::CGL_RG_GATE && gate_min <= max_gain |=> gain_q >= $past(gate_min))
		else $error("gain below gate floor");
	AST_CEILING: assert property (
		region_q != cgl_pkg::CGL_RG_OFF |=> gain_q <= $past(max_gain))
		else $error("gain above ceiling");
	AST_ATTACK_DOWN: assert property (
		step && falling && gain_q > gate_min && gain_q > comp_min && gain_q <= max_gain
		|=> gain_q == $past(gain_q) - 8'h01)
		else $error("attack step did not lower gain");
	AST_DECAY_UP: assert property (
		step && !falling && gain_q < max_gain && gain_q >= comp_min |=> gain_q == $past(gain_q) + 8'h01)
		else $error("decay step did not raise gain");
	AST_QR_RATE: assert property (
		region_q != cgl_pkg::CGL_RG_OFF && !falling && qr_en && crest_hi |-> rate_int == qr_int)
		else $error("fast release rate not used");
	AST_CLIP_BOOST: assert property (
		clip_hit |=> clip_hold_q == `CGL_CLIP_HOLD ##1 atk_int == ((26'(ATK_BASE_CYC) << atk_code) >> `CGL_CLIP_SH))
		else $error("clip guard did not boost attack");
	AST_ACTIVITY: assert property (
		act_d |=> activity_out && status_q[0])
		else $error("activity event lost");
	// Interrupt follows the enabled status one cycle later, so an enable write lags by one
	AST_IRQ_RAISE: assert property (
		(status_q & irq_en_q) != 3'h0 |=> irq_out)
		else $error("enabled status without interrupt");
	AST_IRQ_QUIET: assert property (
		(status_q & irq_en_q) == 3'h0 |=> !irq_out)
		else $error("interrupt without enabled status");
	AST_DET_GATED: assert property (
		!comp_en || !det_en |=> !activity_out)
		else $error("activity without enables");
	AST_PATH_SEL: assert property (
		!path_sel && rec_valid_in |=> lk.vld && lk.smp == $past(rec_sample_in))
		else $error("record path not selected");
	AST_BUS_ANSWER: assert property (
		(read_in || write_in) && waitrequest_out |=> !waitrequest_out ##1 waitrequest_out)
		else $error("bus answer not one cycle");

	COV_CLIP: cover property (clip_hit ##1 clip_hold_q != 8'h00);
	COV_QR: cover property (step && qr_en && crest_hi && !falling);
	COV_GATE: cover property (region_q == cgl_pkg::CGL_RG_GATE && gain_q == gate_min);
	COV_IRQ: cover property (irq_out);
endmodule
`default_nettype wire

// ---- bench/cgl_src_model.sv ----
// Audio sample source standing in for both converter paths
// Assumes calls to send come from one bench process only
`timescale 1ns/1ns
`default_nettype none
module cgl_src_model (
	input wire logic clock_in,
	output var cgl_pkg::cgl_smp_t rec_sample_out = 16'h0000,
	output var logic rec_valid_out = 1'b0,
	output var cgl_pkg::cgl_smp_t play_sample_out = 16'h0000,
	output var logic play_valid_out = 1'b0
);
	// ****
	// Strobe driver
	// ****
	// One-cycle strobe, then a gap; stale data is inverted so it never looks valid
	task automatic send(input logic pl, input cgl_pkg::cgl_smp_t v, input int gap);
		@(posedge clock_in);
		if (pl) begin // Only one path carries a sample at a time
			play_sample_out <= v;
			play_valid_out <= 1'b1;
		end else begin
			rec_sample_out <= v;
			rec_valid_out <= 1'b1;
		end
		@(posedge clock_in);
		play_valid_out <= 1'b0;
		rec_valid_out <= 1'b0;
		play_sample_out <= ~v;
		rec_sample_out <= ~v;
		repeat (gap) @(posedge clock_in);
	endtask
endmodule
`default_nettype wire

// ---- bench/cgl_top_tb.sv ----
// Self-checking bench: registers, sample path, limits, look-ahead, activity
// Assumes the package, interface, design and source model compile first
`timescale 1ns/1ns
`default_nettype none
`include "cgl_params.svh"
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin error_cnt++; $display("BAD %s exp %0h got %0h", n, e, s); end end
module cgl_top_tb;
	// ****
	// Stimulus and model state
	// ****
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	logic [11:0] addr_q = 12'h000;
	logic rd_q = 1'b0;
	logic wr_q = 1'b0;
	logic [31:0] wdata_q = 32'h0000_0000;
	logic [31:0] rdata, rd;
	logic wait_rq, proc_vld, irq, act, rec_vld, play_vld;
	cgl_pkg::cgl_smp_t rec_smp, play_smp, proc_smp;
	int error_cnt = 0;
	int n_checks = 0;
	int seed = 32'h1A85F34C;
	int gain = 16; // Expected gain, Q4.4
	logic sel_pl = 1'b0; // Expected path
	logic clip = 1'b0; // Look-ahead on
	int hist[$]; // Accepted samples
	logic [15:0] exp_q[$];
	logic [15:0] ev;
	always #5 clock_in = ~clock_in;
	cgl_top cgl_top_inst (.clock_in(clock_in), .rst_in(rst_in), .address_in(addr_q), .read_in(rd_q),
		.write_in(wr_q), .writedata_in(wdata_q), .readdata_out(rdata), .waitrequest_out(wait_rq),
		.rec_sample_in(rec_smp), .rec_valid_in(rec_vld), .play_sample_in(play_smp),
		.play_valid_in(play_vld), .proc_sample_out(proc_smp), .proc_valid_out(proc_vld),
		.irq_out(irq), .activity_out(act));
	cgl_src_model cgl_src_model_inst (.clock_in(clock_in), .rec_sample_out(rec_smp),
		.rec_valid_out(rec_vld), .play_sample_out(play_smp), .play_valid_out(play_vld));
	// ****
	// Tasks
	// ****
	// Avalon cycle; held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clock_in);
		addr_q <= {idx, 2'b00};
		wr_q <= wr;
		rd_q <= ~wr;
		wdata_q <= d;
		do begin
			@(posedge clock_in);
			t++;
		end while (wait_rq !== 1'b0 && t < 50);
		if (t >= 50) error_cnt++; // Slave never answered
		rd = rdata;
		wr_q <= 1'b0;
		rd_q <= 1'b0;
	endtask
	task automatic rchk(input logic [9:0] idx, input logic [31:0] m, input logic [31:0] e, input string n);
		bus(1'b0, idx, 32'h0);
		`CHK(n, e, rd & m)
	endtask
	// Send one sample and predict the result
	task automatic snd(input logic pl, input int v);
		int e;
		if (pl === sel_pl) begin // Unselected path gives nothing
			hist.push_back(v);
			e = clip ? (hist.size() > 4 ? hist[hist.size() - 5] : 0) : v;
			e = (e * gain) >>> 4;
			e = e > 32767 ? 32767 : (e < -32768 ? -32768 : e);
			exp_q.push_back(e[15:0]);
		end
		cgl_src_model_inst.send(pl, v[15:0], ($random(seed) & 1) * 2);
	endtask
	task automatic drain(input string n);
		repeat (12) @(posedge clock_in);
		`CHK("left over", 0, exp_q.size())
		$display("test %s done", n);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Every result is compared with the model
	always @(posedge clock_in) begin
		if (proc_vld === 1'b1) begin
			ev = exp_q.size() > 0 ? exp_q.pop_front() : ~proc_smp;
			`CHK("proc_sample", ev, proc_smp)
		end
	end
	// Hang guard, far beyond the few thousand cycles needed
	initial begin
		#500000;
		error_cnt++;
		end_of_test;
	end
	// ****
	// Main sequence
	// ****
	initial begin
		repeat (6) @(posedge clock_in);
		rst_in <= 1'b0;
		rchk(`CGL_IDX_CTRL1, 32'hFFFF, 32'h0008, "ctrl1");
		rchk(`CGL_IDX_CTRL3, 32'hFFFF, 32'h0044, "ctrl3");
		rchk(`CGL_IDX_STATUS, 32'hFFFF, 32'h0, "status");
		rchk(10'h3FF, 32'hFFFFFFFF, 32'h0, "unmapped");
		bus(1'b1, `CGL_IDX_CTRL3, 32'h0F44);
		rchk(`CGL_IDX_CTRL3, 32'hFFFF, 32'h0F44, "ctrl3 wr");
		bus(1'b1, `CGL_IDX_CTRL1, 32'h0);
		rchk(`CGL_IDX_CTRL1, 32'hFFFF, 32'h0, "ctrl1 wr");
		for (int i = 0; i < 12; i++) snd(i % 3 == 0, $random(seed) % int'(16'h3000));
		drain("bypass record");
		bus(1'b1, `CGL_IDX_CTRL1, 32'h2);
		sel_pl = 1'b1;
		for (int i = 0; i < 12; i++) snd(i % 3 != 0, $random(seed) % int'(16'h3000));
		drain("bypass playback");
		sel_pl = 1'b0;
		for (int k = 0; k < 2; k++) begin // Gain pinned below and above unity
			gain = k ? 32 : 8;
			bus(1'b1, `CGL_IDX_LIMIT, gain * 32'h0001_0101);
			bus(1'b1, `CGL_IDX_CTRL1, 32'h1);
			repeat (20) @(posedge clock_in);
			for (int i = 0; i < 8; i++) snd(1'b0, $random(seed) % int'(16'h3000));
			drain("gain clamp");
		end
		gain = 16;
		bus(1'b1, `CGL_IDX_LIMIT, 32'h0010_1010);
		bus(1'b1, `CGL_IDX_CTRL1, 32'h5);
		clip = 1'b1;
		for (int i = 0; i < 10; i++) snd(1'b0, $random(seed) % int'(16'h3000));
		snd(1'b0, int'(16'h7000));
		drain("look-ahead");
		rchk(`CGL_IDX_STATUS, 32'h2, 32'h2, "clip hit");
		bus(1'b1, `CGL_IDX_CLEAR, 32'h2);
		rchk(`CGL_IDX_STATUS, 32'h2, 32'h0, "clip clear");
		bus(1'b1, `CGL_IDX_CTRL1, 32'h1);
		clip = 1'b0;
		for (int i = 0; i < 100; i++) snd(1'b0, int'(16'h4000));
		drain("level build");
		// Fastest codes: attack step every 65 cycles, decay step every 1025
		bus(1'b1, `CGL_IDX_CTRL3, 32'h0);
		bus(1'b1, `CGL_IDX_LIMIT, 32'h0000_2008);
		repeat (600) @(posedge clock_in);
		rchk(`CGL_IDX_LEVEL, 32'h00FF_0000, 32'h0008_0000, "attack floor");
		// Knee out of reach, so the level now counts as low
		bus(1'b1, `CGL_IDX_THRESH, 32'hFF02_1001);
		repeat (2500) @(posedge clock_in);
		rchk(`CGL_IDX_LEVEL, 32'h00FF_0000, 32'h000A_0000, "decay steps");
		bus(1'b1, `CGL_IDX_THRESH, `CGL_THRESH_RST);
		$display("test gain rates done");
		rchk(`CGL_IDX_STATUS, 32'h1, 32'h0, "no detect");
		bus(1'b1, `CGL_IDX_CTRL1, 32'h11);
		repeat (4) @(posedge clock_in);
		`CHK("activity", 1'b1, act)
		rchk(`CGL_IDX_STATUS, 32'h1, 32'h1, "status set");
		bus(1'b1, `CGL_IDX_IRQEN, 32'h1);
		repeat (3) @(posedge clock_in);
		`CHK("irq", 1'b1, irq)
		bus(1'b1, `CGL_IDX_IRQEN, 32'h0);
		repeat (3) @(posedge clock_in);
		`CHK("irq masked", 1'b0, irq)
		bus(1'b1, `CGL_IDX_CTRL1, 32'h31);
		bus(1'b1, `CGL_IDX_CLEAR, 32'h1);
		repeat (3) @(posedge clock_in);
		rchk(`CGL_IDX_STATUS, 32'h1, 32'h0, "peak mode");
		`CHK("activity off", 1'b0, act)
		$display("test activity done");
		end_of_test;
	end
endmodule
`default_nettype wire
